/* logic/bbsb_bank.sv */
// module: battery-backed status and slow clock enable register bank
`timescale 1ns/10ps
module bbsb_bank
    import bbsb_pkg::*;
(
    // clock and battery reset
    input  wire logic        clk,
    input  wire logic        rst,
    // register port
    input  wire logic [7:0]  regAddr,
    input  wire logic        regWrite,
    input  wire logic        regRead,
    input  wire logic [31:0] regWdata,
    output logic      [31:0] regRdata,
    // events and pins
    input  wire logic        watchdogResetEvt,
    input  wire logic        slowClockPresent,
    // oscillator control
    output logic             slowOscEnable,
    output logic             slowOscSourceSelect,
    output logic             ringOscHoldReq,
    // interrupt
    output logic             statusIrq
);
    // ********************************************************
    // status flags
    // ********************************************************
    logic porFlag;
    logic wdogFlag;
    logic wrStatus;
    logic wrClken;

    assign wrStatus = regWrite && (regAddr == OFF_STATUS);
    assign wrClken  = regWrite && (regAddr == OFF_CLKEN);

    bbsb_sticky_flag #(.RESET_VAL(RST_POR_FLAG)) u_por (
        .clk    (clk),
        .rst    (rst),
        .setEvt (1'h0),
        .clrReq (wrStatus && regWdata[BIT_POR_FLAG]),
        .flag   (porFlag)
    );

    bbsb_sticky_flag #(.RESET_VAL(RST_WDOG_FLAG)) u_wdog (
        .clk    (clk),
        .rst    (rst),
        .setEvt (watchdogResetEvt),
        .clrReq (wrStatus && regWdata[BIT_WDOG_FLAG]),
        .flag   (wdogFlag)
    );

    assign statusIrq = porFlag || wdogFlag;

    // ********************************************************
    // clock enable register and ring hold counter
    // ********************************************************
    logic        oscEn_ff;
    logic        nxt_oscEn;
    logic        oscSel_ff;
    logic        nxt_oscSel;
    logic [15:0] hold_ff;
    logic [15:0] nxt_hold;

    always_comb begin
        nxt_oscEn  = oscEn_ff;
        nxt_oscSel = oscSel_ff;
        nxt_hold   = hold_ff;
        if (wrClken) begin
            nxt_oscEn  = regWdata[BIT_OSC_EN];
            nxt_oscSel = regWdata[BIT_OSC_SEL];
        end
        if (wrClken && regWdata[BIT_OSC_EN] && !oscEn_ff) begin
            nxt_hold = 16'(RING_HOLD_CYC);
        end else if (hold_ff != 16'h0000) begin
            nxt_hold = hold_ff - 16'h0001;
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            oscEn_ff  <= RST_OSC_EN;
            oscSel_ff <= RST_OSC_SEL;
            hold_ff   <= 16'h0000;
        end else begin
            oscEn_ff  <= nxt_oscEn;
            oscSel_ff <= nxt_oscSel;
            hold_ff   <= nxt_hold;
        end
    end

    assign slowOscEnable       = oscEn_ff;
    assign slowOscSourceSelect = oscSel_ff;
    assign ringOscHoldReq      = (hold_ff != 16'h0000);

    // ********************************************************
    // read data
    // ********************************************************
    logic [31:0] rdata_ff;
    logic [31:0] nxt_rdata;

    always_comb begin
        nxt_rdata = rdata_ff;
        if (regRead) begin
            nxt_rdata = 32'h00000000;
            case (regAddr)
                OFF_STATUS: begin
                    nxt_rdata[BIT_POR_FLAG] = porFlag;
                    nxt_rdata[BIT_WDOG_FLAG] = wdogFlag;
                    nxt_rdata[BIT_SLOW_DET] = slowClockPresent;
                end
                OFF_CLKEN: begin
                    nxt_rdata[BIT_OSC_EN]  = oscEn_ff;
                    nxt_rdata[BIT_OSC_SEL] = oscSel_ff;
                end
                default: begin
                    nxt_rdata = 32'h00000000;
                end
            endcase
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            rdata_ff <= 32'h00000000;
        end else begin
            rdata_ff <= nxt_rdata;
        end
    end

    assign regRdata = rdata_ff;

    // ********************************************************
    // checks
    // ********************************************************
    localparam logic [31:0] STATUS_USED = (32'h1 << BIT_POR_FLAG) |
        (32'h1 << BIT_WDOG_FLAG) | (32'h1 << BIT_SLOW_DET);
    localparam logic [31:0] CLKEN_USED = (32'h1 << BIT_OSC_EN) |
        (32'h1 << BIT_OSC_SEL);

    sequence s_porClr;
        wrStatus && regWdata[BIT_POR_FLAG];
    endsequence

    sequence s_wdogClr;
        wrStatus && regWdata[BIT_WDOG_FLAG] && !watchdogResetEvt;
    endsequence

    sequence s_oscRise;
        wrClken && regWdata[BIT_OSC_EN] && !slowOscEnable;
    endsequence

    sequence s_statusRead;
        regRead && !regWrite && !watchdogResetEvt &&
            (regAddr == OFF_STATUS);
    endsequence

    a_por_clear: assert property (@(posedge clk)
        disable iff (rst) s_porClr |=> !porFlag)
        else $error("battery reset flag not cleared");
    a_por_hold: assert property (@(posedge clk)
        disable iff (rst)
        (porFlag && !(wrStatus && regWdata[BIT_POR_FLAG])) |=> porFlag)
        else $error("battery reset flag lost");
    a_por_no_set: assert property (@(posedge clk)
        disable iff (rst) !porFlag |=> !porFlag)
        else $error("battery reset flag set without reset");
    a_wdog_set: assert property (@(posedge clk)
        disable iff (rst) watchdogResetEvt |=> wdogFlag)
        else $error("watchdog flag not set");
    a_wdog_clear: assert property (@(posedge clk)
        disable iff (rst) s_wdogClr |=> !wdogFlag)
        else $error("watchdog flag not cleared");
    a_wdog_hold: assert property (@(posedge clk)
        disable iff (rst)
        (wdogFlag && !(wrStatus && regWdata[BIT_WDOG_FLAG])) |=> wdogFlag)
        else $error("watchdog flag lost");
    a_irq_flags: assert property (@(posedge clk)
        disable iff (rst) s_statusRead |=>
            statusIrq == (regRdata[BIT_POR_FLAG] || regRdata[BIT_WDOG_FLAG]))
        else $error("interrupt does not follow flags");
    a_det_live: assert property (@(posedge clk)
        disable iff (rst) s_statusRead |=>
            regRdata[BIT_SLOW_DET] == $past(slowClockPresent))
        else $error("clock detect bit not live");
    a_status_rsvd: assert property (@(posedge clk)
        disable iff (rst) s_statusRead |=>
            (regRdata & ~STATUS_USED) == 32'h00000000)
        else $error("status reserved bits not zero");
    a_clken_rsvd: assert property (@(posedge clk)
        disable iff (rst) (regRead && (regAddr == OFF_CLKEN)) |=>
            (regRdata & ~CLKEN_USED) == 32'h00000000)
        else $error("enable reserved bits not zero");
    a_rsvd_zero: assert property (@(posedge clk)
        disable iff (rst) (regRead && (regAddr == OFF_RESERVED)) |=>
            regRdata == 32'h00000000)
        else $error("reserved word not zero");
    a_rd_hold: assert property (@(posedge clk)
        disable iff (rst) !regRead |=> $stable(regRdata))
        else $error("read data moved without read");
    a_osc_only_write: assert property (@(posedge clk)
        disable iff (rst) !wrClken |=> $stable(slowOscEnable))
        else $error("oscillator enable moved without write");
    a_osc_on: assert property (@(posedge clk)
        disable iff (rst) (wrClken && regWdata[BIT_OSC_EN]) |=> slowOscEnable)
        else $error("clock enable write not taken");
    a_osc_off: assert property (@(posedge clk)
        disable iff (rst) (wrClken && !regWdata[BIT_OSC_EN]) |=>
            !slowOscEnable)
        else $error("clock disable write not taken");
    a_sel_one: assert property (@(posedge clk)
        disable iff (rst) (wrClken && regWdata[BIT_OSC_SEL]) |=>
            slowOscSourceSelect)
        else $error("source select set not taken");
    a_sel_zero: assert property (@(posedge clk)
        disable iff (rst) (wrClken && !regWdata[BIT_OSC_SEL]) |=>
            !slowOscSourceSelect)
        else $error("source select clear not taken");
    a_hold_start: assert property (@(posedge clk)
        disable iff (rst) s_oscRise |=> ringOscHoldReq)
        else $error("ring hold not started");
    a_ring_hold: assert property (@(posedge clk)
        disable iff (rst) $rose(slowOscEnable) |-> ringOscHoldReq [*8])
        else $error("ring hold dropped early");
    a_hold_idle: assert property (@(posedge clk)
        disable iff (rst)
        (!ringOscHoldReq && !(wrClken && regWdata[BIT_OSC_EN])) |=>
            !ringOscHoldReq)
        else $error("ring hold raised without enable");
endmodule

/* logic/bbsb_pkg.sv */
// package: offsets, field positions, reset values and timing counts
package bbsb_pkg;
    // ********************************************************
    // register offsets
    // ********************************************************
    localparam logic [7:0] OFF_STATUS   = 8'h00;
    localparam logic [7:0] OFF_RESERVED = 8'h04;
    localparam logic [7:0] OFF_CLKEN    = 8'h08;
    // ********************************************************
    // field positions
    // ********************************************************
    localparam int BIT_POR_FLAG = 7;
    localparam int BIT_WDOG_FLAG = 5;
    localparam int BIT_SLOW_DET = 0;
    localparam int BIT_OSC_EN   = 1;
    localparam int BIT_OSC_SEL  = 0;
    // ********************************************************
    // reset values
    // ********************************************************
    localparam logic RST_POR_FLAG = 1'h1;
    localparam logic RST_WDOG_FLAG = 1'h0;
    localparam logic RST_OSC_EN   = 1'h0;
    localparam logic RST_OSC_SEL  = 1'h0;
    // ********************************************************
    // timing
    // ********************************************************
    localparam int CLK_HZ        = 20000000;
    localparam int RING_HOLD_US  = 40;
    localparam int RING_HOLD_CYC = (RING_HOLD_US * (CLK_HZ / 1000000));
endpackage

/* logic/bbsb_sticky_flag.sv */
// module: one write-one-to-clear sticky flag with set priority
`timescale 1ns/10ps
module bbsb_sticky_flag #(
    parameter logic RESET_VAL = 1'h0
) (
    // clock and reset
    input  wire logic clk,
    input  wire logic rst,
    // set and clear
    input  wire logic setEvt,
    input  wire logic clrReq,
    // state
    output logic      flag
);
    logic flag_ff;
    logic nxt_flag;

    always_comb begin
        nxt_flag = flag_ff;
        if (clrReq) begin
            nxt_flag = 1'h0;
        end
        if (setEvt) begin
            nxt_flag = 1'h1;
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            flag_ff <= RESET_VAL;
        end else begin
            flag_ff <= nxt_flag;
        end
    end

    assign flag = flag_ff;
endmodule

/* verification/battery_backed_status_bank_test.sv */
// testbench: register access sequences for the status bank
`timescale 1ns/10ps
module battery_backed_status_bank_test
    import bbsb_pkg::*;
;
    // ********************************************************
    // signals and instance
    // ********************************************************
    logic        clk;
    logic        rst;
    logic [7:0]  regAddr;
    logic        regWrite;
    logic        regRead;
    logic [31:0] regWdata;
    logic [31:0] regRdata;
    logic        watchdogResetEvt;
    logic        slowClockPresent;
    logic        slowOscEnable;
    logic        slowOscSourceSelect;
    logic        ringOscHoldReq;
    logic        statusIrq;
    int          numErrors;
    int          testsRun;
    int          cycles;
    int          holdCnt;

    bbsb_bank uut (
        .clk                 (clk),
        .rst                 (rst),
        .regAddr             (regAddr),
        .regWrite            (regWrite),
        .regRead             (regRead),
        .regWdata            (regWdata),
        .regRdata            (regRdata),
        .watchdogResetEvt    (watchdogResetEvt),
        .slowClockPresent    (slowClockPresent),
        .slowOscEnable       (slowOscEnable),
        .slowOscSourceSelect (slowOscSourceSelect),
        .ringOscHoldReq      (ringOscHoldReq),
        .statusIrq           (statusIrq)
    );
    // ********************************************************
    // tasks
    // ********************************************************
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        testsRun++;
        if (seen !== exp) begin
            numErrors++;
            $display("ERROR %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        #1 regAddr = a;
        regWdata = d;
        regWrite = 1'h1;
        @(posedge clk);
        #1 regWrite = 1'h0;
    endtask

    task automatic rd(input logic [7:0] a, input logic [31:0] exp);
        @(posedge clk);
        #1 regAddr = a;
        regRead = 1'h1;
        @(posedge clk);
        #1 regRead = 1'h0;
        check(regRdata, exp);
    endtask

    task automatic wdPulse();
        @(posedge clk);
        #1 watchdogResetEvt = 1'h1;
        @(posedge clk);
        #1 watchdogResetEvt = 1'h0;
    endtask

    task automatic closeOut();
        $display("errors %0d checks %0d", numErrors, testsRun);
        if (numErrors == 0 && testsRun > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask
    // ********************************************************
    // clock, timeout, sequence
    // ********************************************************
    initial begin
        clk = 1'h0;
        forever #25 clk = ~clk;
    end

    always @(posedge clk) begin
        cycles++;
        if (cycles == 5000) begin
            numErrors++;
            closeOut();
        end
    end

    initial begin
        rst = 1'h1;
        {regWrite, regRead, watchdogResetEvt} = 3'h0;
        regAddr = 8'h00;
        regWdata = 32'h0;
        slowClockPresent = 1'h1;
        repeat (8) @(posedge clk);
        #1 rst = 1'h0;
        check({31'h0, statusIrq}, 32'h1);
        rd(OFF_STATUS, 32'h81);
        rd(OFF_CLKEN, 32'h0);
        wr(OFF_STATUS, 32'hFFFF_FF5F);
        rd(OFF_STATUS, 32'h81);
        wr(OFF_STATUS, 32'h80);
        slowClockPresent = 1'h0;
        rd(OFF_STATUS, 32'h0);
        check({31'h0, statusIrq}, 32'h0);
        wdPulse();
        rd(OFF_STATUS, 32'h20);
        check({31'h0, statusIrq}, 32'h1);
        wr(OFF_STATUS, 32'hFFFF_FF5F);
        rd(OFF_STATUS, 32'h20);
        wr(OFF_STATUS, 32'h20);
        rd(OFF_STATUS, 32'h0);
        wr(OFF_CLKEN, 32'h1);
        check({slowOscEnable, slowOscSourceSelect}, 32'h1);
        check(ringOscHoldReq, 32'h0);
        wr(OFF_CLKEN, 32'h3);
        holdCnt = 0;
        while (ringOscHoldReq === 1'h1 && holdCnt < 2000) begin
            holdCnt++;
            @(posedge clk);
            #1;
        end
        check(holdCnt, RING_HOLD_CYC);
        rd(OFF_CLKEN, 32'h3);
        wr(OFF_CLKEN, 32'hFFFF_FFFF);
        rd(OFF_CLKEN, 32'h3);
        check(ringOscHoldReq, 32'h0);
        wr(OFF_RESERVED, 32'hFFFF_FFFF);
        rd(OFF_RESERVED, 32'h0);
        rd(8'h0C, 32'h0);
        wdPulse();
        check({slowOscEnable, slowOscSourceSelect}, 32'h3);
        wr(OFF_CLKEN, 32'h2);
        rd(OFF_CLKEN, 32'h2);
        wr(OFF_CLKEN, 32'h0);
        rd(OFF_CLKEN, 32'h0);
        wr(OFF_CLKEN, 32'h1);
        wr(OFF_CLKEN, 32'h3);
        check(ringOscHoldReq, 32'h1);
        @(posedge clk);
        #1 rst = 1'h1;
        #5;
        check({statusIrq, slowOscEnable, slowOscSourceSelect}, 32'h4);
        check(ringOscHoldReq, 32'h0);
        @(posedge clk);
        #1 rst = 1'h0;
        slowClockPresent = 1'h1;
        rd(OFF_STATUS, 32'h81);
        rd(OFF_CLKEN, 32'h0);
        closeOut();
    end
endmodule
